// ### fpp_cfg.svh
// Constants for the fuse programming sequencer.
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH
`define FPP_CLK_MHZ 250
`define FPP_STEP_DELAY_US 10
`define FPP_PULSE_US 1500
`define FPP_REST_US 4000
`define FPP_SETTLE_US 10
`define FPP_STEP_CYC ((`FPP_STEP_DELAY_US) * (`FPP_CLK_MHZ))
`define FPP_PULSE_CYC ((`FPP_PULSE_US) * (`FPP_CLK_MHZ))
`define FPP_REST_CYC ((`FPP_REST_US) * (`FPP_CLK_MHZ))
`define FPP_SETTLE_CYC ((`FPP_SETTLE_US) * (`FPP_CLK_MHZ))
`define FPP_ADDR_W 9
`define FPP_DATA_W 4
`define FPP_CNT_W 21
`endif

// ### fpp_pkg.sv
// Types for the fuse programming sequencer.
package fpp_pkg;
  typedef enum logic [1:0] {
    FPP_SUP_OFF = 2'h0,
    FPP_SUP_LOW = 2'h1,
    FPP_SUP_HIGH = 2'h2,
    FPP_SUP_PROG = 2'h3
  } fpp_supply_t;
  typedef enum logic [3:0] {
    FPP_IDLE = 4'h0,
    FPP_SEL = 4'h1,
    FPP_FUSE_ON = 4'h3,
    FPP_PULSE = 4'h2,
    FPP_HOLD = 4'h6,
    FPP_FUSE_OFF = 4'h7,
    FPP_VER_HI = 4'h5,
    FPP_VER_LO = 4'h4,
    FPP_REST = 4'hc,
    FPP_DONE = 4'hd
  } fpp_state_t;
endpackage : fpp_pkg

// ### fpp_sync.sv
// Two-stage synchroniser for the sensed output comparators.
`timescale 1ns/10ps
module fpp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;
  always_comb
  begin
    meta_next = clk_en_i ? async_i : meta_reg;
    sync_next = clk_en_i ? meta_reg : sync_reg;
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  assign sync_o = sync_reg;
endmodule : fpp_sync

// ### fpp_programmer.sv
// Programmer that fuses the selected bits of one memory word, one at a time, and verifies each.
`timescale 1ns/10ps
`include "fpp_cfg.svh"
module fpp_programmer #(
  parameter int STEP_CYC = `FPP_STEP_CYC,
  parameter int PULSE_CYC = `FPP_PULSE_CYC,
  parameter int REST_CYC = `FPP_REST_CYC,
  parameter int SETTLE_CYC = `FPP_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire logic [`FPP_ADDR_W-1:0] addr_i,
  input wire logic [`FPP_DATA_W-1:0] bits_i,
  input wire logic [`FPP_DATA_W-1:0] sense_above_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic [`FPP_DATA_W-1:0] fail_bits_o,
  output logic [`FPP_ADDR_W-1:0] mem_addr_o,
  output fpp_pkg::fpp_supply_t supply_sel_o,
  output logic [`FPP_DATA_W-1:0] fuse_en_o,
  output logic chip_en_n_o
);
  fpp_pkg::fpp_state_t state_reg;
  fpp_pkg::fpp_state_t state_next;
  logic [`FPP_CNT_W-1:0] cnt_reg;
  logic [`FPP_CNT_W-1:0] cnt_next;
  logic [`FPP_ADDR_W-1:0] addr_reg;
  logic [`FPP_ADDR_W-1:0] addr_next;
  logic [`FPP_DATA_W-1:0] todo_reg;
  logic [`FPP_DATA_W-1:0] todo_next;
  logic [`FPP_DATA_W-1:0] cur_reg;
  logic [`FPP_DATA_W-1:0] cur_next;
  logic [`FPP_DATA_W-1:0] fail_reg;
  logic [`FPP_DATA_W-1:0] fail_next;
  fpp_pkg::fpp_supply_t sup_reg;
  fpp_pkg::fpp_supply_t sup_next;
  logic [`FPP_DATA_W-1:0] fuse_reg;
  logic [`FPP_DATA_W-1:0] fuse_next;
  logic ce_n_reg;
  logic ce_n_next;
  logic done_reg;
  logic done_next;
  logic busy_reg;
  logic busy_next;
  logic fail_any_reg;
  logic fail_any_next;
  logic [`FPP_DATA_W-1:0] sense;
  logic [`FPP_DATA_W-1:0] low_bit;
  logic cnt_end;

  // Comparator outputs are asynchronous to this clock.
  fpp_sync #(
    .WIDTH(`FPP_DATA_W)
  ) u_sense_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .async_i(sense_above_i),
    .sync_o(sense)
  );

  assign cnt_end = (cnt_reg == '0);
  // Lowest pending bit; one output is fused at a time.
  assign low_bit = todo_reg & (~todo_reg + `FPP_DATA_W'(1));

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_end ? cnt_reg : cnt_reg - `FPP_CNT_W'(1);
    addr_next = addr_reg;
    todo_next = todo_reg;
    cur_next = cur_reg;
    fail_next = fail_reg;
    sup_next = sup_reg;
    fuse_next = fuse_reg;
    ce_n_next = ce_n_reg;
    done_next = 1'b0;
    unique case (state_reg)
      fpp_pkg::FPP_IDLE:
      begin
        if (start_i)
        begin
          addr_next = addr_i;
          todo_next = bits_i;
          fail_next = '0;
          state_next = fpp_pkg::FPP_SEL;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
      end
      fpp_pkg::FPP_SEL:
      begin
        // Address is already stable before supply rises.
        sup_next = fpp_pkg::FPP_SUP_PROG;
        if (todo_reg == '0)
        begin
          sup_next = fpp_pkg::FPP_SUP_OFF;
          state_next = fpp_pkg::FPP_DONE;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
        else if (cnt_end && sup_reg == fpp_pkg::FPP_SUP_PROG)
        begin
          cur_next = low_bit;
          fuse_next = low_bit;
          state_next = fpp_pkg::FPP_FUSE_ON;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
      end
      fpp_pkg::FPP_FUSE_ON:
        if (cnt_end)
        begin
          ce_n_next = 1'b0;
          state_next = fpp_pkg::FPP_PULSE;
          cnt_next = `FPP_CNT_W'(PULSE_CYC);
        end
      fpp_pkg::FPP_PULSE:
        if (cnt_end)
        begin
          ce_n_next = 1'b1;
          state_next = fpp_pkg::FPP_HOLD;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
      fpp_pkg::FPP_HOLD:
        if (cnt_end)
        begin
          fuse_next = '0;
          state_next = fpp_pkg::FPP_FUSE_OFF;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
      fpp_pkg::FPP_FUSE_OFF:
        if (cnt_end)
        begin
          sup_next = fpp_pkg::FPP_SUP_HIGH;
          ce_n_next = 1'b0;
          state_next = fpp_pkg::FPP_VER_HI;
          cnt_next = `FPP_CNT_W'(SETTLE_CYC);
        end
      fpp_pkg::FPP_VER_HI:
        if (cnt_end)
        begin
          // A read above threshold is a fused one.
          if ((sense & cur_reg) == '0)
            fail_next = fail_reg | cur_reg;
          sup_next = fpp_pkg::FPP_SUP_LOW;
          state_next = fpp_pkg::FPP_VER_LO;
          cnt_next = `FPP_CNT_W'(SETTLE_CYC);
        end
      fpp_pkg::FPP_VER_LO:
        if (cnt_end)
        begin
          if ((sense & cur_reg) == '0)
            fail_next = fail_reg | cur_reg;
          ce_n_next = 1'b1;
          sup_next = fpp_pkg::FPP_SUP_OFF;
          todo_next = todo_reg & ~cur_reg;
          state_next = fpp_pkg::FPP_REST;
          cnt_next = `FPP_CNT_W'(REST_CYC);
        end
      fpp_pkg::FPP_REST:
        // The rest after every cycle keeps duty well under a third.
        if (cnt_end)
        begin
          state_next = fpp_pkg::FPP_SEL;
          cnt_next = `FPP_CNT_W'(STEP_CYC);
        end
      fpp_pkg::FPP_DONE:
        if (cnt_end)
        begin
          done_next = 1'b1;
          state_next = fpp_pkg::FPP_IDLE;
        end
      default:
        state_next = fpp_pkg::FPP_IDLE;
    endcase
    busy_next = (state_next != fpp_pkg::FPP_IDLE);
    fail_any_next = |fail_next;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= fpp_pkg::FPP_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      todo_reg <= '0;
      cur_reg <= '0;
      fail_reg <= '0;
      sup_reg <= fpp_pkg::FPP_SUP_OFF;
      fuse_reg <= '0;
      ce_n_reg <= 1'b1;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      fail_any_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      todo_reg <= todo_next;
      cur_reg <= cur_next;
      fail_reg <= fail_next;
      sup_reg <= sup_next;
      fuse_reg <= fuse_next;
      ce_n_reg <= ce_n_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      fail_any_reg <= fail_any_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign fail_o = fail_any_reg;
  assign fail_bits_o = fail_reg;
  assign mem_addr_o = addr_reg;
  assign supply_sel_o = sup_reg;
  assign fuse_en_o = fuse_reg;
  assign chip_en_n_o = ce_n_reg;

  property p_one_fuse;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $onehot0(fuse_reg);
  endproperty
  a_one_fuse: assert property (p_one_fuse)
    else $error("More than one output driven to fuse voltage.");

  property p_fuse_needs_prog;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (fuse_reg != '0) |-> sup_reg == fpp_pkg::FPP_SUP_PROG;
  endproperty
  a_fuse_needs_prog: assert property (p_fuse_needs_prog)
    else $error("Fuse voltage without programming supply.");

  property p_pulse_fuse;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!ce_n_reg && sup_reg == fpp_pkg::FPP_SUP_PROG) |-> fuse_reg != '0;
  endproperty
  a_pulse_fuse: assert property (p_pulse_fuse)
    else $error("Enable pulse without fuse voltage.");

  property p_fuse_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(ce_n_reg) && state_reg == fpp_pkg::FPP_HOLD
        |-> fuse_reg != '0;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("Fuse voltage removed with the enable pulse.");

  property p_ver_hi;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_reg == fpp_pkg::FPP_VER_HI |->
        sup_reg == fpp_pkg::FPP_SUP_HIGH && !ce_n_reg;
  endproperty
  a_ver_hi: assert property (p_ver_hi)
    else $error("Upper verify without its supply or enable.");

  property p_ver_lo;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_reg == fpp_pkg::FPP_VER_LO |->
        sup_reg == fpp_pkg::FPP_SUP_LOW && fuse_reg == '0;
  endproperty
  a_ver_lo: assert property (p_ver_lo)
    else $error("Lower verify without its supply.");

  property p_rest;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_reg == fpp_pkg::FPP_REST |-> sup_reg == fpp_pkg::FPP_SUP_OFF;
  endproperty
  a_rest: assert property (p_rest)
    else $error("Supply not off during rest.");

  property p_done;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      done_reg |-> sup_reg == fpp_pkg::FPP_SUP_OFF && ce_n_reg;
  endproperty
  a_done: assert property (p_done)
    else $error("Done raised with supply on.");

  sequence s_pulse_end;
    state_reg == fpp_pkg::FPP_PULSE ##1 state_reg == fpp_pkg::FPP_HOLD;
  endsequence
  sequence s_fuse_still_on;
    ce_n_reg && fuse_reg != '0 && sup_reg == fpp_pkg::FPP_SUP_PROG;
  endsequence
  property p_pulse_then_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_pulse_end |-> s_fuse_still_on;
  endproperty
  a_pulse_then_hold: assert property (p_pulse_then_hold)
    else $error("Fuse voltage not held after the enable pulse.");
endmodule : fpp_programmer

// ### fpp_prom_model.sv
// Behavioural fuse memory that answers the programmer at its pins.
`timescale 1ns/10ps
module fpp_prom_model (
  input wire fpp_pkg::fpp_supply_t supply_sel_i,
  input wire logic [8:0] mem_addr_i,
  input wire logic [3:0] fuse_en_i,
  input wire logic chip_en_n_i,
  input wire logic [3:0] stuck_i,
  input wire logic [3:0] marginal_i,
  output logic [3:0] sense_above_o,
  output int fuse_count_o
);
  logic [3:0] mem [512];
  initial
  begin
    fuse_count_o = 0;
    for (int i = 0; i < 512; i++)
      mem[i] = 4'h0;
  end
  // A stuck bit ignores the pulse, so a bench can provoke a failed verify.
  always @(negedge chip_en_n_i)
  begin
    if (supply_sel_i == fpp_pkg::FPP_SUP_PROG && $onehot(fuse_en_i))
    begin
      mem[mem_addr_i] = mem[mem_addr_i] | (fuse_en_i & ~stuck_i);
      fuse_count_o++;
    end
  end
  always @*
  begin
    if (supply_sel_i == fpp_pkg::FPP_SUP_OFF)
      sense_above_o = 4'h0;
    else if (chip_en_n_i)
      sense_above_o = 4'hf; // Pull-ups hold released outputs high.
    // A marginal link reads one at the upper level but drops at the lower.
    else if (supply_sel_i == fpp_pkg::FPP_SUP_LOW)
      sense_above_o = mem[mem_addr_i] & ~marginal_i;
    else
      sense_above_o = mem[mem_addr_i] | fuse_en_i;
  end
endmodule : fpp_prom_model

// ### fpp_programmer_bench.sv
// Self-checking bench for the fuse programming sequencer.
`timescale 1ns/10ps
module fpp_programmer_bench;
  localparam int STEP = 4;
  localparam int REST = 16;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic start_i = 1'b0;
  logic [8:0] addr_i = 9'h000;
  logic [3:0] bits_i = 4'h0;
  logic [3:0] stuck = 4'h0;
  logic [3:0] marginal = 4'h0;
  logic [3:0] sense, fail_bits, fuse_en, p_fuse;
  logic busy, done, fail, ce_n, p_ce, p_done, rest_due;
  logic [8:0] mem_addr, p_addr;
  fpp_pkg::fpp_supply_t sup, p_sup;
  int fuses, c_prog, c_fuse, c_ce, c_cehi, c_off;
  int miscompares = 0;
  int n_compared = 0;
  fpp_programmer #(.STEP_CYC(STEP), .PULSE_CYC(6), .REST_CYC(REST),
    .SETTLE_CYC(4)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .start_i(start_i), .addr_i(addr_i),
    .bits_i(bits_i), .sense_above_i(sense), .busy_o(busy), .done_o(done),
    .fail_o(fail), .fail_bits_o(fail_bits), .mem_addr_o(mem_addr),
    .supply_sel_o(sup), .fuse_en_o(fuse_en), .chip_en_n_o(ce_n));
  fpp_prom_model prom (.supply_sel_i(sup), .mem_addr_i(mem_addr),
    .fuse_en_i(fuse_en), .chip_en_n_i(ce_n), .stuck_i(stuck),
    .marginal_i(marginal),
    .sense_above_o(sense), .fuse_count_o(fuses));
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc
  task automatic go(input logic [8:0] a, input logic [3:0] b);
    cyc(1);
    start_i = 1'b1;
    addr_i = a;
    bits_i = b;
    cyc(1);
    start_i = 1'b0;
  endtask : go
  task automatic wait_done();
    int k;
    for (k = 0; k < 2000 && done !== 1'b1; k++)
      cyc(1);
    chk(done === 1'b1, "no done");
  endtask : wait_done
  // Counters stop with clk_en_i so a frozen phase is not read as too long.
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {c_prog, c_fuse, c_ce, c_cehi, c_off} = '0;
      {p_fuse, p_ce, p_done, rest_due, p_addr} = {4'h0, 3'b100, 9'h000};
      p_sup = fpp_pkg::FPP_SUP_OFF;
    end
    else if (clk_en_i)
    begin
      chk($onehot0(fuse_en), "two outputs fused");
      chk(!(done && p_done), "long done");
      if (sup != fpp_pkg::FPP_SUP_OFF)
        chk(mem_addr === p_addr, "address moved");
      if (fuse_en != 4'h0 && p_fuse == 4'h0)
        chk(sup == fpp_pkg::FPP_SUP_PROG && c_prog >= STEP, "fuse early");
      if (!ce_n && p_ce && fuse_en != 4'h0)
        chk(c_fuse >= STEP, "pulse early");
      if (ce_n && !p_ce && fuse_en != 4'h0)
        chk(c_ce >= 4 && c_ce <= 8, "pulse width");
      if (fuse_en == 4'h0 && p_fuse != 4'h0)
        chk(c_cehi >= STEP, "fuse removed early");
      if (sup == fpp_pkg::FPP_SUP_PROG && rest_due)
        chk(c_off >= REST, "rest short");
      if (sup != p_sup)
        rest_due = (sup == fpp_pkg::FPP_SUP_LOW) ? 1'b1 : rest_due;
      if (sup == fpp_pkg::FPP_SUP_PROG)
        rest_due = 1'b0;
      c_prog = (sup == fpp_pkg::FPP_SUP_PROG) ? c_prog + 1 : 0;
      c_off = (sup == fpp_pkg::FPP_SUP_OFF) ? c_off + 1 : 0;
      c_fuse = (fuse_en != 4'h0) ? c_fuse + 1 : 0;
      c_ce = ce_n ? 0 : c_ce + 1;
      c_cehi = ce_n ? c_cehi + 1 : 0;
      {p_fuse, p_ce, p_done, p_addr} = {fuse_en, ce_n, done, mem_addr};
      p_sup = sup;
    end
  end
  task automatic t_basic();
    int f;
    int k;
    f = fuses;
    go(9'h1a5, 4'h5);
    cyc(2);
    start_i = 1'b1;
    addr_i = 9'h0aa;
    bits_i = 4'hf;
    cyc(1);
    start_i = 1'b0;
    chk(mem_addr === 9'h1a5, "start taken while busy");
    for (k = 0; k < 200 && ce_n !== 1'b0; k++)
      cyc(1);
    clk_en_i = 1'b0;
    cyc(20);
    chk(ce_n === 1'b0 && busy === 1'b1, "not frozen");
    clk_en_i = 1'b1;
    wait_done();
    chk(fail_bits === 4'h0 && fail === 1'b0, "false fail");
    chk(prom.mem[9'h1a5] === 4'h5, "word wrong");
    chk(prom.mem[9'h0aa] === 4'h0, "refused word fused");
    chk(fuses - f == 2, "attempt count");
  endtask : t_basic
  task automatic t_full();
    int f;
    f = fuses;
    go(9'h1ff, 4'hf);
    wait_done();
    chk(prom.mem[9'h1ff] === 4'hf && fuses - f == 4, "full word");
    go(9'h000, 4'h8);
    wait_done();
    chk(prom.mem[9'h000] === 4'h8 && fail === 1'b0, "next word");
  endtask : t_full
  task automatic t_fail();
    stuck = 4'h2;
    go(9'h003, 4'h6);
    wait_done();
    chk(fail_bits === 4'h2 && fail === 1'b1, "fail flag");
    chk(prom.mem[9'h003] === 4'h4, "good bit lost");
    stuck = 4'h0;
    marginal = 4'h1;
    go(9'h005, 4'h1);
    wait_done();
    chk(fail_bits === 4'h1 && fail === 1'b1, "low verify");
    marginal = 4'h0;
    go(9'h004, 4'h0);
    wait_done();
    chk(fail_bits === 4'h0 && fail === 1'b0, "fail kept");
  endtask : t_fail
  task automatic t_reset();
    int k;
    go(9'h155, 4'h1);
    for (k = 0; k < 200 && ce_n !== 1'b0; k++)
      cyc(1);
    chk(ce_n === 1'b0, "no pulse");
    reset_n_i = 1'b0;
    #1;
    chk(ce_n === 1'b1 && sup === fpp_pkg::FPP_SUP_OFF, "reset pins");
    chk(fuse_en === 4'h0 && busy === 1'b0 && done === 1'b0, "reset st");
    cyc(3);
    reset_n_i = 1'b1;
    go(9'h156, 4'h1);
    wait_done();
    chk(prom.mem[9'h156] === 4'h1, "after reset");
  endtask : t_reset
  initial
  begin
    cyc(16);
    reset_n_i = 1'b1;
    t_basic();
    t_full();
    t_fail();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    cyc(6000);
    miscompares++;
    report_and_stop();
  end
endmodule : fpp_programmer_bench
